// ==== mei_pkg.sv ====
// constants, register offsets and state codes for the motion event interrupt block
// assumes the registers are reached through a byte-wide register port fed by the serial slave
package mei_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_KNOCK_LEVEL = 8'h1d;
  localparam logic [7:0] ADDR_KNOCK_LENGTH = 8'h21;
  localparam logic [7:0] ADDR_KNOCK_GAP = 8'h22;
  localparam logic [7:0] ADDR_KNOCK_SPAN = 8'h23;
  localparam logic [7:0] ADDR_MOTION_LEVEL = 8'h24;
  localparam logic [7:0] ADDR_MOTION_AXIS = 8'h27;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2e;
  localparam logic [7:0] ADDR_IRQ_ROUTE = 8'h2f;
  localparam logic [7:0] ADDR_IRQ_CAUSE = 8'h30;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h31;
  localparam logic [7:0] ADDR_SAMPLE_FIRST = 8'h32;
  localparam logic [7:0] ADDR_SAMPLE_LAST = 8'h37;
  // number of sample bytes (x low, x high, y low, y high, z low, z high)
  localparam int SAMPLE_BYTES = 6;
  // function fields in enable, route and cause registers: bits 7..4
  localparam int NUM_FUNC = 4;
  localparam int FUNC_LSB = 4;
  localparam int FUNC_MSB = 7;
  // index within the 4-bit function vector
  localparam int FN_NEW = 3;
  localparam int FN_SINGLE = 2;
  localparam int FN_DOUBLE = 1;
  localparam int FN_MOTION = 0;
  // output polarity bit in the format register
  localparam int BIT_INVERT = 5;
  // axis participation bits in the axis select register
  localparam int BIT_AXIS_X = 6;
  localparam int BIT_AXIS_Y = 5;
  localparam int BIT_AXIS_Z = 4;
  // reset value of every writable register
  localparam logic [7:0] REG_RESET = 8'h00;
  // magnitude scaling from sample lsb to level lsb
  localparam int MAG_SHIFT = 4;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // knock detector states, gray along idle-first-gap-span-second
  typedef enum logic [2:0] {
    K_IDLE = 3'b000,
    K_FIRST = 3'b001,
    K_GAP = 3'b011,
    K_SPAN = 3'b010,
    K_SECOND = 3'b110
  } mei_knock_t;
endpackage : mei_pkg

// ==== mei_axis_cmp.sv ====
// one axis: absolute value of a signed sample compared against two levels
// assumes levels use an lsb 2**MAG_SHIFT times coarser than the sample
`timescale 1ns/10ps
module mei_axis_cmp #(
  parameter int SAMPLE_W = 16
) (
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic [7:0] level_a,
  input wire logic [7:0] level_b,
  output logic over_a,
  output logic over_b
);
  logic [SAMPLE_W-1:0] mag;
  logic [SAMPLE_W-1:0] scaled;

  // most negative value folds onto itself, still reads as large
  always_comb begin
    mag = sample[SAMPLE_W-1] ? SAMPLE_W'(~sample + 1'b1) : sample;
    scaled = mag >> mei_pkg::MAG_SHIFT;
    over_a = scaled > SAMPLE_W'(level_a);
    over_b = scaled > SAMPLE_W'(level_b);
  end
endmodule : mei_axis_cmp

// ==== mei_pin_drv.sv ====
// one interrupt pin: gates latched flags by enable and route, applies polarity, registers the pin
// assumes flags, enables and routes are aligned function vectors from the register file
`timescale 1ns/10ps
module mei_pin_drv #(
  parameter int NF = 4,
  parameter bit PIN_SECOND = 1'b0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [NF-1:0] flags,
  input wire logic [NF-1:0] enable,
  input wire logic [NF-1:0] route,
  input wire logic invert,
  output logic pin_q
);
  logic [NF-1:0] routed;
  logic pin_d;

  // functions on one pin are or-ed together, none excludes another
  always_comb begin
    routed = PIN_SECOND ? route : ~route; // RULE_15
    pin_d = (|(flags & enable & routed)) ^ invert; // RULE_05 RULE_14 RULE_02
  end

  // push-pull pin, always driven, one flop deep
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d; // RULE_01
    end
  end
endmodule : mei_pin_drv

// ==== mei_motion_irq.sv ====
// motion event interrupt block: register file, event detectors, latched flags, two pins
// assumes a serial slave issues one-cycle reg_wr/reg_rd strobes and a sampler pulses sample_valid
// Overview of operation
// RULE_01: two separately driven push-pull interrupt pins
// RULE_02: pins active high, format bit five inverts
// RULE_03: a function drives pins only when enabled
// RULE_04: route register picks each function's pin
// RULE_05: functions run together and share pins
// RULE_06: host sets functions and routes before enabling
// RULE_07: host disables function before reconfiguring it
// RULE_08: data flag clears after samples fully read
// RULE_09: cause register read clears other flags
// RULE_10: new-sample flag set on fresh data
// RULE_11: short above-level event sets single knock
// RULE_12: two short events within window: double
// RULE_13: motion above level on selected axis
// RULE_14: pin active while routed enabled flag set
// RULE_15: route zero first pin, one second
`timescale 1ns/10ps
module mei_motion_irq #(
  parameter int SAMPLE_W = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] x_axis_sample,
  input wire logic [SAMPLE_W-1:0] y_axis_sample,
  input wire logic [SAMPLE_W-1:0] z_axis_sample,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic irq_out_first,
  output logic irq_out_second
);
  localparam int NF = mei_pkg::NUM_FUNC;
  localparam int NB = mei_pkg::SAMPLE_BYTES;

  // writable registers
  logic [7:0] knock_level_q, knock_level_d;
  logic [7:0] knock_length_limit_q, knock_length_limit_d;
  logic [7:0] knock_gap_delay_q, knock_gap_delay_d;
  logic [7:0] second_knock_span_q, second_knock_span_d;
  logic [7:0] motion_level_q, motion_level_d;
  logic [7:0] motion_axis_select_q, motion_axis_select_d;
  logic [7:0] irq_enable_mask_q, irq_enable_mask_d;
  logic [7:0] irq_pin_route_q, irq_pin_route_d;
  logic [7:0] output_format_q, output_format_d;
  logic [7:0] reg_rdata_d;

  // sample store, read tracking, flags, knock detector
  logic [8*NB-1:0] sample_q, sample_d;
  logic [NB-1:0] read_mask_q, read_mask_d;
  logic [NF-1:0] flag_q, flag_d;
  mei_pkg::mei_knock_t knock_q, knock_d;
  logic [7:0] cnt_q, cnt_d;

  logic [2:0][SAMPLE_W-1:0] axis_w;
  logic [2:0] knock_over_w, motion_over_w;
  logic [2:0] axis_sel_w;
  logic knock_over, motion_hit;
  logic [7:0] cnt_inc;
  logic set_single, set_double;
  logic rd_cause, rd_sample;
  logic [NB-1:0] byte_hit;
  logic [7:0] sample_idx;
  logic [7:0] cause_w;

  assign axis_w = {z_axis_sample, y_axis_sample, x_axis_sample};
  assign axis_sel_w = {motion_axis_select_q[mei_pkg::BIT_AXIS_Z],
                       motion_axis_select_q[mei_pkg::BIT_AXIS_Y],
                       motion_axis_select_q[mei_pkg::BIT_AXIS_X]};

  // per-axis level comparators, knock uses every axis
  for (genvar a = 0; a < 3; a++) begin : g_axis
    mei_axis_cmp #(.SAMPLE_W(SAMPLE_W)) u_cmp (
      .sample(axis_w[a]),
      .level_a(knock_level_q),
      .level_b(motion_level_q),
      .over_a(knock_over_w[a]),
      .over_b(motion_over_w[a])
    );
  end

  // decode of strobes and cause view
  always_comb begin
    knock_over = |knock_over_w;
    motion_hit = |(motion_over_w & axis_sel_w); // RULE_13
    rd_cause = reg_rd && (reg_addr == mei_pkg::ADDR_IRQ_CAUSE);
    rd_sample = reg_rd && (reg_addr >= mei_pkg::ADDR_SAMPLE_FIRST) && (reg_addr <= mei_pkg::ADDR_SAMPLE_LAST);
    sample_idx = reg_addr - mei_pkg::ADDR_SAMPLE_FIRST;
    byte_hit = '0;
    if (rd_sample) begin
      byte_hit[sample_idx[2:0]] = 1'b1;
    end
    cause_w = '0;
    cause_w[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB] = flag_q;
    cnt_inc = (cnt_q == mei_pkg::CNT_MAX) ? cnt_q : cnt_q + mei_pkg::CNT_STEP;
  end

  // register writes and registered read data; unmapped reads give zero
  always_comb begin
    knock_level_d = knock_level_q;
    knock_length_limit_d = knock_length_limit_q;
    knock_gap_delay_d = knock_gap_delay_q;
    second_knock_span_d = second_knock_span_q;
    motion_level_d = motion_level_q;
    motion_axis_select_d = motion_axis_select_q;
    irq_enable_mask_d = irq_enable_mask_q;
    irq_pin_route_d = irq_pin_route_q;
    output_format_d = output_format_q;
    if (reg_wr) begin
      case (reg_addr)
        mei_pkg::ADDR_KNOCK_LEVEL: knock_level_d = reg_wdata;
        mei_pkg::ADDR_KNOCK_LENGTH: knock_length_limit_d = reg_wdata;
        mei_pkg::ADDR_KNOCK_GAP: knock_gap_delay_d = reg_wdata;
        mei_pkg::ADDR_KNOCK_SPAN: second_knock_span_d = reg_wdata;
        mei_pkg::ADDR_MOTION_LEVEL: motion_level_d = reg_wdata;
        mei_pkg::ADDR_MOTION_AXIS: motion_axis_select_d = reg_wdata;
        mei_pkg::ADDR_IRQ_ENABLE: irq_enable_mask_d = reg_wdata; // RULE_03
        mei_pkg::ADDR_IRQ_ROUTE: irq_pin_route_d = reg_wdata; // RULE_04
        mei_pkg::ADDR_OUT_FORMAT: output_format_d = reg_wdata; // RULE_02
        default: ;
      endcase
    end
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        mei_pkg::ADDR_KNOCK_LEVEL: reg_rdata_d = knock_level_q;
        mei_pkg::ADDR_KNOCK_LENGTH: reg_rdata_d = knock_length_limit_q;
        mei_pkg::ADDR_KNOCK_GAP: reg_rdata_d = knock_gap_delay_q;
        mei_pkg::ADDR_KNOCK_SPAN: reg_rdata_d = second_knock_span_q;
        mei_pkg::ADDR_MOTION_LEVEL: reg_rdata_d = motion_level_q;
        mei_pkg::ADDR_MOTION_AXIS: reg_rdata_d = motion_axis_select_q;
        mei_pkg::ADDR_IRQ_ENABLE: reg_rdata_d = irq_enable_mask_q;
        mei_pkg::ADDR_IRQ_ROUTE: reg_rdata_d = irq_pin_route_q;
        mei_pkg::ADDR_IRQ_CAUSE: reg_rdata_d = cause_w;
        mei_pkg::ADDR_OUT_FORMAT: reg_rdata_d = output_format_q;
        default: reg_rdata_d = rd_sample ? sample_q[8*sample_idx[2:0] +: 8] : '0;
      endcase
    end
  end

  // knock detector, counts in sample periods
  always_comb begin
    knock_d = knock_q;
    cnt_d = cnt_q;
    set_single = 1'b0;
    set_double = 1'b0;
    if (sample_valid) begin
      case (knock_q)
        mei_pkg::K_IDLE: begin
          if (knock_over) begin
            knock_d = mei_pkg::K_FIRST;
            cnt_d = mei_pkg::CNT_STEP;
          end
        end
        mei_pkg::K_FIRST: begin
          if (knock_over) begin
            cnt_d = cnt_inc;
          end else if (cnt_q < knock_length_limit_q) begin
            set_single = 1'b1; // RULE_11
            knock_d = mei_pkg::K_GAP;
            cnt_d = '0;
          end else begin
            knock_d = mei_pkg::K_IDLE; // too long: no knock
          end
        end
        mei_pkg::K_GAP: begin
          // events inside the latency are ignored
          if (cnt_inc >= knock_gap_delay_q) begin
            knock_d = mei_pkg::K_SPAN;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_inc;
          end
        end
        mei_pkg::K_SPAN: begin
          if (knock_over) begin
            knock_d = mei_pkg::K_SECOND;
            cnt_d = mei_pkg::CNT_STEP;
          end else if (cnt_inc >= second_knock_span_q) begin
            knock_d = mei_pkg::K_IDLE;
          end else begin
            cnt_d = cnt_inc;
          end
        end
        mei_pkg::K_SECOND: begin
          if (knock_over) begin
            cnt_d = cnt_inc;
          end else begin
            set_double = cnt_q < knock_length_limit_q; // RULE_12
            knock_d = mei_pkg::K_IDLE;
          end
        end
        default: knock_d = mei_pkg::K_IDLE;
      endcase
    end
  end

  // sample store and latched flags; a set always beats a same-cycle clear
  always_comb begin
    sample_d = sample_q;
    read_mask_d = read_mask_q | byte_hit;
    flag_d = flag_q;
    if (rd_cause) begin
      flag_d[mei_pkg::FN_SINGLE] = 1'b0; // RULE_09
      flag_d[mei_pkg::FN_DOUBLE] = 1'b0;
      flag_d[mei_pkg::FN_MOTION] = 1'b0;
    end
    if (&read_mask_d) begin
      flag_d[mei_pkg::FN_NEW] = 1'b0; // RULE_08
    end
    if (sample_valid) begin
      sample_d = {z_axis_sample, y_axis_sample, x_axis_sample};
      read_mask_d = '0;
      flag_d[mei_pkg::FN_NEW] = 1'b1; // RULE_10
      if (motion_hit) begin
        flag_d[mei_pkg::FN_MOTION] = 1'b1; // RULE_13
      end
    end
    if (set_single) begin
      flag_d[mei_pkg::FN_SINGLE] = 1'b1;
    end
    if (set_double) begin
      flag_d[mei_pkg::FN_DOUBLE] = 1'b1;
    end
  end

  // all state registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      knock_level_q <= mei_pkg::REG_RESET;
      knock_length_limit_q <= mei_pkg::REG_RESET;
      knock_gap_delay_q <= mei_pkg::REG_RESET;
      second_knock_span_q <= mei_pkg::REG_RESET;
      motion_level_q <= mei_pkg::REG_RESET;
      motion_axis_select_q <= mei_pkg::REG_RESET;
      irq_enable_mask_q <= mei_pkg::REG_RESET;
      irq_pin_route_q <= mei_pkg::REG_RESET;
      output_format_q <= mei_pkg::REG_RESET;
      reg_rdata_q <= '0;
      sample_q <= '0;
      read_mask_q <= '0;
      flag_q <= '0;
      knock_q <= mei_pkg::K_IDLE;
      cnt_q <= '0;
    end else begin
      knock_level_q <= knock_level_d;
      knock_length_limit_q <= knock_length_limit_d;
      knock_gap_delay_q <= knock_gap_delay_d;
      second_knock_span_q <= second_knock_span_d;
      motion_level_q <= motion_level_d;
      motion_axis_select_q <= motion_axis_select_d;
      irq_enable_mask_q <= irq_enable_mask_d;
      irq_pin_route_q <= irq_pin_route_d;
      output_format_q <= output_format_d;
      reg_rdata_q <= reg_rdata_d;
      sample_q <= sample_d;
      read_mask_q <= read_mask_d;
      flag_q <= flag_d;
      knock_q <= knock_d;
      cnt_q <= cnt_d;
    end
  end

  // the two pins, identical except for which route value they take
  mei_pin_drv #(.NF(NF), .PIN_SECOND(1'b0)) u_pin_first (
    .core_clk(core_clk),
    .resetn(resetn),
    .flags(flag_q),
    .enable(irq_enable_mask_q[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB]),
    .route(irq_pin_route_q[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB]),
    .invert(output_format_q[mei_pkg::BIT_INVERT]),
    .pin_q(irq_out_first)
  );
  mei_pin_drv #(.NF(NF), .PIN_SECOND(1'b1)) u_pin_second (
    .core_clk(core_clk),
    .resetn(resetn),
    .flags(flag_q),
    .enable(irq_enable_mask_q[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB]),
    .route(irq_pin_route_q[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB]),
    .invert(output_format_q[mei_pkg::BIT_INVERT]),
    .pin_q(irq_out_second)
  );

  // checks
  logic [NF-1:0] en_w, rt_w;
  logic inv_w;
  assign en_w = irq_enable_mask_q[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB];
  assign rt_w = irq_pin_route_q[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB];
  assign inv_w = output_format_q[mei_pkg::BIT_INVERT];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_pin_first;
    ##1 irq_out_first == ((|$past(flag_q & en_w & ~rt_w)) ^ $past(inv_w));
  endproperty
  a_pin_first: assert property (p_pin_first) else $error("first pin wrong"); // RULE_14

  property p_pin_second;
    (|(flag_q & en_w & rt_w)) && !inv_w |=> irq_out_second;
  endproperty
  a_pin_second: assert property (p_pin_second) else $error("second pin not raised"); // RULE_15

  property p_polarity;
    (flag_q & en_w) == '0 && inv_w |=> irq_out_first && irq_out_second;
  endproperty
  a_polarity: assert property (p_polarity) else $error("idle level not inverted"); // RULE_02

  property p_disabled;
    en_w == '0 && !inv_w |=> !irq_out_first && !irq_out_second;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled function drives pin"); // RULE_03

  property p_shared;
    $countones(flag_q & en_w & ~rt_w) > 1 && !inv_w |=> irq_out_first;
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin dropped"); // RULE_05

  property p_cause_clear;
    rd_cause && !sample_valid && knock_q == mei_pkg::K_IDLE |=> flag_q[2:0] == '0;
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("cause read did not clear"); // RULE_09

  property p_cause_data;
    rd_cause |=> reg_rdata_q[mei_pkg::FUNC_MSB:mei_pkg::FUNC_LSB] == $past(flag_q);
  endproperty
  a_cause_data: assert property (p_cause_data) else $error("cause read data wrong"); // RULE_09

  property p_new_set;
    sample_valid |=> flag_q[mei_pkg::FN_NEW] && read_mask_q == '0;
  endproperty
  a_new_set: assert property (p_new_set) else $error("new sample flag not set"); // RULE_10

  property p_new_hold;
    flag_q[mei_pkg::FN_NEW] && !(&(read_mask_q | byte_hit)) |=> flag_q[mei_pkg::FN_NEW];
  endproperty
  a_new_hold: assert property (p_new_hold) else $error("new flag lost early"); // RULE_08

  property p_motion;
    sample_valid && motion_hit |=> flag_q[mei_pkg::FN_MOTION];
  endproperty
  a_motion: assert property (p_motion) else $error("motion flag missed"); // RULE_13

  property p_single;
    sample_valid && knock_q == mei_pkg::K_FIRST && !knock_over && cnt_q < knock_length_limit_q
      |=> flag_q[mei_pkg::FN_SINGLE] && knock_q == mei_pkg::K_GAP;
  endproperty
  a_single: assert property (p_single) else $error("single knock missed"); // RULE_11

  property p_double;
    sample_valid && knock_q == mei_pkg::K_SECOND && !knock_over && cnt_q < knock_length_limit_q
      |=> flag_q[mei_pkg::FN_DOUBLE] && knock_q == mei_pkg::K_IDLE;
  endproperty
  a_double: assert property (p_double) else $error("double knock missed"); // RULE_12

  c_double: cover property (set_double ##[1:20] irq_out_second);
  // flag lands one edge after the set, the pin one edge later
  c_single: cover property (set_single ##2 irq_out_second);
  c_inverted: cover property (inv_w && !irq_out_first);
  c_drain: cover property (flag_q[mei_pkg::FN_NEW] ##[1:12] !flag_q[mei_pkg::FN_NEW]);
endmodule : mei_motion_irq

// ==== mei_host_model.sv ====
// host side of the two interrupt pins: decodes pin levels into active flags
// assumes the host is told the programmed polarity; pins are push-pull, so no pull level
`timescale 1ns/10ps
module mei_host_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic irq_out_first,
  input wire logic irq_out_second,
  input wire logic invert,
  output logic [1:0] host_seen_q
);
  logic [1:0] host_seen_d;
  // polarity removed before registering, as a host input stage would
  always_comb begin
    host_seen_d = {irq_out_second, irq_out_first} ^ {2{invert}};
  end
  // one sampling flop; adds a cycle of latency the bench allows for
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      host_seen_q <= 2'h0;
    end else begin
      host_seen_q <= host_seen_d;
    end
  end
endmodule : mei_host_model

// ==== testbench.sv ====
// self-checking bench for the motion event interrupt block with a flag and pin model
// assumes one-cycle register strobes and read data one cycle after the read edge
`timescale 1ns/10ps
module testbench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] xs = 16'h0000;
  logic [15:0] ys = 16'h0000;
  logic [15:0] zs = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  logic irq_out_first;
  logic irq_out_second;
  logic [1:0] host_seen_q;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 15;
  // bench model: flags new/single/double/motion, enables, routes, polarity
  logic [3:0] m_flag = 4'h0;
  logic [3:0] m_en = 4'h0;
  logic [3:0] m_rt = 4'h0;
  logic m_inv = 1'b0;
  logic [7:0] rd_v;
  logic [7:0] d;
  logic [47:0] m_smp = 48'h0;
  logic [7:0] regs [9] = '{8'h1d, 8'h21, 8'h22, 8'h23, 8'h24, 8'h27, 8'h2e, 8'h2f, 8'h31};
  localparam logic [15:0] KN = 16'h0000;
  localparam logic [15:0] KE = 16'h0100;

  always #12.5 core_clk = ~core_clk;

  mei_motion_irq u_dut (.core_clk(core_clk), .resetn(resetn), .sample_valid(sample_valid),
    .x_axis_sample(xs), .y_axis_sample(ys), .z_axis_sample(zs), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .irq_out_first(irq_out_first), .irq_out_second(irq_out_second));

  mei_host_model u_host (.core_clk(core_clk), .resetn(resetn), .irq_out_first(irq_out_first),
    .irq_out_second(irq_out_second), .invert(m_inv), .host_seen_q(host_seen_q));

  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data lands on the edge that ends the strobe
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata_q;
  endtask : rd

  task smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    xs <= x;
    ys <= y;
    zs <= z;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    m_smp = {z, y, x};
    m_flag[3] = 1'b1;
  endtask : smp

  // pins one cycle behind flags, host stage one more
  task pins;
    logic [1:0] e;
    repeat (3) @(posedge core_clk);
    #1 e = {|(m_flag & m_en & m_rt), |(m_flag & m_en & ~m_rt)};
    check({6'h0, irq_out_second, irq_out_first}, {6'h0, e ^ {2{m_inv}}});
    check({6'h0, host_seen_q}, {6'h0, e});
  endtask : pins

  task cause;
    rd(8'h30);
    check(rd_v, {m_flag, 4'h0});
    m_flag[2:0] = 3'h0;
  endtask : cause

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    // reset values, random readback, refused writes
    foreach (regs[i]) begin
      rd(regs[i]);
      check(rd_v, 8'h00);
      d = 8'($random(seed));
      wr(regs[i], d);
      rd(regs[i]);
      check(rd_v, d);
    end
    foreach (regs[i]) wr(regs[i], 8'h00);
    wr(8'h30, 8'hff);
    wr(8'h32, 8'h5a);
    wr(8'h25, 8'ha5);
    cause();
    rd(8'h32);
    check(rd_v, 8'h00);
    rd(8'h25);
    check(rd_v, 8'h00);
    $display("test registers done");
    // motion on y only; configure before enabling
    wr(8'h24, 8'h10);
    wr(8'h27, 8'h20);
    wr(8'h2f, 8'h80);
    m_rt = 4'h8;
    wr(8'h2e, 8'h90);
    m_en = 4'h9;
    smp(16'h0200, KN, KN);
    pins();
    cause();
    smp(KN, 16'h010f, KN);
    cause();
    smp(KN, 16'h0110 + 16'(($random(seed)) & 16'h00ff), KN);
    m_flag[0] = 1'b1;
    pins();
    for (int i = 0; i < 2; i++) begin
      m_inv = i[0];
      wr(8'h31, {2'h0, m_inv, 5'h00});
      pins();
    end
    wr(8'h2f, 8'h90);
    m_rt = 4'h9;
    pins();
    cause();
    pins();
    smp(KN, 16'hfe00, KN);
    m_flag[0] = 1'b1;
    pins();
    for (int i = 0; i < 6; i++) begin
      rd(8'h32 + 8'(i));
      check(rd_v, m_smp[8 * i +: 8]);
      if (i == 5) m_flag[3] = 1'b0;
      pins();
    end
    // x and z selected, y left out: y may not raise motion
    wr(8'h27, 8'h50);
    cause();
    smp(KN, 16'h0400, KN);
    cause();
    smp(KN, KN, 16'hfc00);
    m_flag[0] = 1'b1;
    cause();
    wr(8'h31, 8'h00);
    m_inv = 1'b0;
    cause();
    $display("test motion done");
    // knock: disable first, reconfigure, enable again
    wr(8'h2e, 8'h00);
    m_en = 4'h0;
    wr(8'h27, 8'h00);
    wr(8'h1d, 8'h02);
    wr(8'h21, 8'h04);
    wr(8'h22, 8'h01);
    wr(8'h23, 8'h08);
    wr(8'h2f, 8'h40);
    m_rt = 4'h4;
    wr(8'h2e, 8'h60);
    m_en = 4'h6;
    // four above-level samples reach the limit: no knock
    repeat (4) smp(KE, KN, KN);
    smp(KN, KN, KN);
    pins();
    cause();
    // three long, then a second short one after the gap
    repeat (3) smp(KN, KN, KE);
    smp(KN, KN, KN);
    m_flag[2] = 1'b1;
    pins();
    smp(KN, KN, KN);
    smp(KN, KE, KN);
    smp(KN, KN, KN);
    m_flag[1] = 1'b1;
    pins();
    cause();
    pins();
    $display("test knock done");
    stop_test();
  end
endmodule : testbench
